// ---- shared/ium_regs.vh ----
`ifndef IUM_REGS_VH
`define IUM_REGS_VH
// ----------------------------------------
// Host-side addresses
// ----------------------------------------
`define IUM_ADDR_CTRL_H2C 32'h83F00030
`define IUM_ADDR_CTRL_C2H 32'h83F00034
`define IUM_ADDR_STEP_EN 32'h83F00020
`define IUM_ADDR_MAN_CLK 32'h83F00024
`define IUM_ADDR_DAT_HIGH 32'h83F00038
`define IUM_ADDR_DAT_LOW 32'h83F0003C
// ----------------------------------------
// Core-side addresses
// ----------------------------------------
`define IUM_CADDR_STEP 12'hFF6
`define IUM_CADDR_MANCLK 12'hFF7
`define IUM_CADDR_BOOT 12'hFF8
`define IUM_CADDR_NEW_COMMAND_FLAG 12'hFF9
`define IUM_CADDR_RDTRK 12'hFFA
`define IUM_CADDR_DAT_HIGH 12'hFFC
`define IUM_CADDR_DAT_LOW 12'hFFD
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define IUM_BIT_BOOT 0
`define IUM_BIT_NEW_COMMAND_FLAG 1
`define IUM_BIT_STEP 2
`define IUM_BIT_MANCLK 3
`define IUM_BIT_RDTRK 7
`define IUM_CTRL_WMASK 8'h0F
`define IUM_CTRL_RESET 8'h00
`define IUM_IMEM_DEPTH 256
`define IUM_NOP_WORD 16'h0000
`endif

// ---- hdl/ium_mailbox.v ----
`timescale 1ns/1ps
`include "ium_regs.vh"
module ium_mailbox (
  input wire I_CLK,
  input wire I_ARST_N,
  input wire [31:0] I_HOST_ADDR,
  input wire [7:0] I_HOST_WDATA,
  input wire I_HOST_CS,
  input wire I_HOST_WE,
  output reg [7:0] O_HOST_RDATA,
  input wire I_CORE_RST_N,
  input wire [11:0] I_CORE_ADDR,
  input wire [7:0] I_CORE_WDATA,
  input wire I_CORE_CS,
  input wire I_CORE_WE,
  output reg [7:0] O_CORE_RDATA,
  input wire [7:0] I_CORE_PC,
  output reg [15:0] O_CORE_INSTR,
  output reg O_BOOT_MODE,
  output reg O_STEP_EN,
  output reg O_MAN_CLK
);

// ----------------------------------------
// Input synchronisers
// ----------------------------------------
reg [31:0] h_addr_m, h_addr;
reg [7:0] h_wdata_m, h_wdata;
reg h_cs_m, h_cs, h_we_m, h_we, h_cs_d;
reg c_rst_m, c_rst;
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N) begin
    h_addr_m <= 32'h00000000;
    h_addr <= 32'h00000000;
    h_wdata_m <= 8'h00;
    h_wdata <= 8'h00;
    h_cs_m <= 1'b0;
    h_cs <= 1'b0;
    h_we_m <= 1'b0;
    h_we <= 1'b0;
    h_cs_d <= 1'b0;
    c_rst_m <= 1'b0;
    c_rst <= 1'b0;
  end else begin
    h_addr_m <= I_HOST_ADDR;
    h_addr <= h_addr_m;
    h_wdata_m <= I_HOST_WDATA;
    h_wdata <= h_wdata_m;
    h_cs_m <= I_HOST_CS;
    h_cs <= h_cs_m;
    h_we_m <= I_HOST_WE;
    h_we <= h_we_m;
    h_cs_d <= h_cs;
    c_rst_m <= I_CORE_RST_N;
    c_rst <= c_rst_m;
  end
end

// Access seen once, at the start of a host strobe
wire h_acc = h_cs & ~h_cs_d;
wire h_wr = h_acc & h_we;
wire h_rd = h_acc & ~h_we;

function hit;
  input [31:0] a;
  input [31:0] b;
  begin
    hit = (a == b);
  end
endfunction

wire c_wr = I_CORE_CS & I_CORE_WE;
wire c_rd = I_CORE_CS & ~I_CORE_WE;

// ----------------------------------------
// Host-to-core control pair
// ----------------------------------------
reg [7:0] h2c_in, h2c_out;
reg h2c_rd_in, h2c_rd_out;
reg [7:0] dat_high, dat_low;
reg core_rd_dat;
wire h2c_wr = h_wr & hit(h_addr, `IUM_ADDR_CTRL_H2C);
wire h2c_osel = c_rd & (I_CORE_ADDR[11:4] == 8'hFF);
wire fresh_word = h_wr & hit(h_addr, `IUM_ADDR_DAT_LOW);
wire [7:0] ctrl_wdata = h_wdata & `IUM_CTRL_WMASK;
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N) begin
    h2c_in <= `IUM_CTRL_RESET;
    h2c_out <= `IUM_CTRL_RESET;
    h2c_rd_in <= 1'b0;
    h2c_rd_out <= 1'b0;
    dat_high <= 8'h00;
    dat_low <= 8'h00;
  end else begin
    if (h2c_wr)
      h2c_in[3:0] <= ctrl_wdata[3:0];
    // New word raises the flag; core read of low byte drops it
    if (fresh_word)
      h2c_in[`IUM_BIT_NEW_COMMAND_FLAG] <= 1'b1;
    else if (core_rd_dat)
      h2c_in[`IUM_BIT_NEW_COMMAND_FLAG] <= 1'b0;
    if (!h2c_osel)
      h2c_out <= h2c_in;
    if (h2c_wr || fresh_word) begin
      h2c_rd_in <= 1'b0;
      h2c_rd_out <= 1'b0;
    end else begin
      if (h2c_osel)
        h2c_rd_in <= 1'b1;
      h2c_rd_out <= h2c_rd_in;
    end
    if (h_wr && hit(h_addr, `IUM_ADDR_DAT_HIGH))
      dat_high <= h_wdata;
    if (fresh_word)
      dat_low <= h_wdata;
  end
end
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N)
    core_rd_dat <= 1'b0;
  else
    core_rd_dat <= c_rd & (I_CORE_ADDR == `IUM_CADDR_DAT_LOW);
end

// ----------------------------------------
// Core-to-host control pair
// ----------------------------------------
reg [7:0] c2h_in, c2h_out;
reg c2h_rd_in, c2h_rd_out;
wire c2h_wr = c_wr & (I_CORE_ADDR[11:4] == 8'hFF);
wire c2h_osel = h_rd & hit(h_addr, `IUM_ADDR_CTRL_C2H);
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N) begin
    c2h_in <= `IUM_CTRL_RESET;
    c2h_out <= `IUM_CTRL_RESET;
    c2h_rd_in <= 1'b0;
    c2h_rd_out <= 1'b0;
  end else begin
    if (c2h_wr)
      c2h_in[3:0] <= I_CORE_WDATA[3:0];
    if (!c2h_osel)
      c2h_out <= c2h_in;
    if (c2h_wr) begin
      c2h_rd_in <= 1'b0;
      c2h_rd_out <= 1'b0;
    end else begin
      if (c2h_osel)
        c2h_rd_in <= 1'b1;
      c2h_rd_out <= c2h_rd_in;
    end
  end
end

// ----------------------------------------
// Step enable, manual clock, boot mode
// ----------------------------------------
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N) begin
    O_STEP_EN <= 1'b0;
    O_MAN_CLK <= 1'b0;
    O_BOOT_MODE <= 1'b0;
  end else begin
    if (h_wr && hit(h_addr, `IUM_ADDR_STEP_EN))
      O_STEP_EN <= h_wdata[0];
    // One pulse per access edge; host paces four per instruction
    O_MAN_CLK <= h_acc & hit(h_addr, `IUM_ADDR_MAN_CLK);
    // Mode latched only while core is held in reset
    if (!c_rst)
      O_BOOT_MODE <= h2c_out[`IUM_BIT_BOOT];
  end
end

// ----------------------------------------
// Instruction memory and boot ROM
// ----------------------------------------
reg [15:0] imem [0:`IUM_IMEM_DEPTH-1];
reg [15:0] boot_rom [0:3];
initial begin
  boot_rom[0] = 16'h0000;
  boot_rom[1] = 16'h0000;
  boot_rom[2] = 16'h0000;
  boot_rom[3] = 16'h0000;
end
// Loader target pointer; advances per consumed word
reg [7:0] wr_ptr;
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N)
    wr_ptr <= 8'h00;
  else if (!O_BOOT_MODE)
    wr_ptr <= 8'h00;
  else if (core_rd_dat)
    wr_ptr <= wr_ptr + 8'h01;
end
always @(posedge I_CLK) begin
  if (O_BOOT_MODE && core_rd_dat)
    imem[wr_ptr] <= {dat_high, dat_low};
end
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N)
    O_CORE_INSTR <= `IUM_NOP_WORD;
  else if (O_BOOT_MODE)
    O_CORE_INSTR <= boot_rom[I_CORE_PC[1:0]];
  else
    O_CORE_INSTR <= imem[I_CORE_PC];
end

// ----------------------------------------
// Read paths
// ----------------------------------------
reg [7:0] next_core_rdata, next_host_rdata;
always @* begin
  next_core_rdata = 8'h00;
  case (I_CORE_ADDR)
    `IUM_CADDR_BOOT:
      next_core_rdata = {7'h00, h2c_out[`IUM_BIT_BOOT]};
    `IUM_CADDR_NEW_COMMAND_FLAG: next_core_rdata = {7'h00, h2c_out[`IUM_BIT_NEW_COMMAND_FLAG]};
    `IUM_CADDR_STEP: next_core_rdata = {7'h00, h2c_out[`IUM_BIT_STEP]};
    `IUM_CADDR_MANCLK: next_core_rdata = {7'h00, h2c_out[`IUM_BIT_MANCLK]};
    `IUM_CADDR_RDTRK: next_core_rdata = {7'h00, h2c_rd_out};
    `IUM_CADDR_DAT_HIGH: next_core_rdata = dat_high;
    `IUM_CADDR_DAT_LOW: next_core_rdata = dat_low;
    default: next_core_rdata = 8'h00;
  endcase
end
always @* begin
  next_host_rdata = 8'h00;
  if (hit(h_addr, `IUM_ADDR_CTRL_C2H))
    next_host_rdata = {c2h_rd_out, 3'h0, c2h_out[3:0]};
  else if (hit(h_addr, `IUM_ADDR_CTRL_H2C))
    next_host_rdata = {h2c_rd_out, 3'h0, h2c_in[3:0]};
  else if (hit(h_addr, `IUM_ADDR_STEP_EN))
    next_host_rdata = {7'h00, O_STEP_EN};
  else if (hit(h_addr, `IUM_ADDR_DAT_HIGH))
    next_host_rdata = dat_high;
  else if (hit(h_addr, `IUM_ADDR_DAT_LOW))
    next_host_rdata = dat_low;
end
always @(posedge I_CLK or negedge I_ARST_N) begin
  if (!I_ARST_N) begin
    O_HOST_RDATA <= 8'h00;
    O_CORE_RDATA <= 8'h00;
  end else begin
    O_HOST_RDATA <= next_host_rdata;
    O_CORE_RDATA <= next_core_rdata;
  end
end

endmodule // ium_mailbox

// ---- sim/ium_mailbox_asserts.sv ----
`timescale 1ns/1ps
module ium_mailbox_asserts (
  input wire I_CLK,
  input wire I_ARST_N,
  input wire [31:0] I_HOST_ADDR,
  input wire I_HOST_CS,
  input wire I_CORE_RST_N,
  input wire [7:0] O_HOST_RDATA,
  input wire O_BOOT_MODE,
  input wire O_STEP_EN,
  input wire O_MAN_CLK
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  reg [3:0] idle;
  // Saturates so an old host access never excuses a late change
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      idle <= 4'hF;
    else
      idle <= I_HOST_CS ? 4'h0 : idle + {3'h0, idle != 4'hF};
  end
  man_pulse_a: assert property (O_MAN_CLK |=> !O_MAN_CLK)
    else $error("manual clock wider than one cycle");
  man_cause_a: assert property (O_MAN_CLK |-> idle < 4'h6)
    else $error("manual clock without host access");
  step_cause_a: assert property (
    $changed(O_STEP_EN) |-> idle < 4'h6)
    else $error("step enable moved without host access");
  boot_latch_a: assert property (
    I_CORE_RST_N [*5] |-> $stable(O_BOOT_MODE))
    else $error("boot mode moved while core runs");
  reset_quiet_a: assert property ($rose(I_ARST_N) |-> !O_BOOT_MODE && !O_MAN_CLK)
    else $error("outputs not idle after reset");
  unmapped_zero_a: assert property ((I_HOST_ADDR == 32'h83F00040) [*5]
    |-> O_HOST_RDATA == 8'h00) else $error("unmapped read not zero");
  ctrl_spare_a: assert property ((I_HOST_ADDR == 32'h83F00030) [*5]
    |-> O_HOST_RDATA[6:4] == 3'h0) else $error("spare control bits set");
  back_spare_a: assert property ((I_HOST_ADDR == 32'h83F00034) [*5]
    |-> O_HOST_RDATA[6:4] == 3'h0) else $error("spare return bits set");
  cover property ($rose(O_BOOT_MODE));
  cover property ($fell(O_BOOT_MODE));
  cover property (O_MAN_CLK);
endmodule // ium_mailbox_asserts

// ---- sim/ium_host_model.sv ----
`timescale 1ns/1ps
`include "ium_regs.vh"
module ium_host_model (
  input wire i_clk,
  input wire [7:0] i_rdata,
  output reg [31:0] o_addr = 32'h00000000,
  output reg [7:0] o_wdata = 8'h00,
  output reg o_cs = 1'b0,
  output reg o_we = 1'b0,
  output reg o_core_rst_n = 1'b1
);
  // Held six cycles: the strobe is synchronised before it is taken
  task access(input [31:0] a, input [7:0] d, input w, output [7:0] q);
    begin
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_we <= w;
      o_cs <= 1'b1;
      repeat (6) @(posedge i_clk);
      q = i_rdata;
      o_cs <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
      repeat (4) @(posedge i_clk);
    end
  endtask
  task core_reset;
    begin
      @(posedge i_clk);
      o_core_rst_n <= 1'b0;
      repeat (5) @(posedge i_clk);
      o_core_rst_n <= 1'b1;
      repeat (5) @(posedge i_clk);
    end
  endtask
  task send_word(input [15:0] w, output [7:0] q);
    begin
      access(`IUM_ADDR_DAT_HIGH, w[15:8], 1'b1, q);
      access(`IUM_ADDR_DAT_LOW, w[7:0], 1'b1, q);
    end
  endtask
endmodule // ium_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "ium_regs.vh"
module tb_top;
  reg I_CLK, I_ARST_N, core_cs, core_we;
  reg [11:0] core_addr;
  reg [7:0] core_wdata, core_pc, q;
  wire [31:0] h_addr;
  wire [7:0] h_wdata, h_rdata, core_rdata;
  wire [15:0] instr;
  wire h_cs, h_we, core_rst_n, boot, step_en, man_clk;
  reg [47:0] rows [0:3];
  integer failures, check_count, cycles, pulses, i;
  ium_mailbox ium_mailbox_inst (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .I_HOST_ADDR(h_addr), .I_HOST_WDATA(h_wdata), .I_HOST_CS(h_cs),
    .I_HOST_WE(h_we), .O_HOST_RDATA(h_rdata), .I_CORE_RST_N(core_rst_n),
    .I_CORE_ADDR(core_addr), .I_CORE_WDATA(core_wdata), .I_CORE_CS(core_cs),
    .I_CORE_WE(core_we), .O_CORE_RDATA(core_rdata), .I_CORE_PC(core_pc),
    .O_CORE_INSTR(instr), .O_BOOT_MODE(boot), .O_STEP_EN(step_en),
    .O_MAN_CLK(man_clk));
  ium_host_model ium_host_model_inst (.i_clk(I_CLK), .i_rdata(h_rdata),
    .o_addr(h_addr), .o_wdata(h_wdata), .o_cs(h_cs), .o_we(h_we),
    .o_core_rst_n(core_rst_n));
  initial begin
    I_CLK = 1'b0;
    forever #10 I_CLK = ~I_CLK;
  end
  always @(posedge I_CLK) begin
    cycles = cycles + 1;
    if (man_clk === 1'b1) pulses = pulses + 1;
    if (cycles == 3000) begin
      failures = failures + 1;
      conclude;
    end
  end
  task chk(input [47:0] n, input [15:0] e, input [15:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task h(input [31:0] a, input [7:0] d, input w);
    ium_host_model_inst.access(a, d, w, q);
  endtask
  task c(input [11:0] a, input [7:0] d, input w);
    begin
      @(posedge I_CLK);
      core_addr <= a;
      core_wdata <= d;
      core_we <= w;
      core_cs <= 1'b1;
      @(posedge I_CLK);
      core_cs <= 1'b0;
      #1;
      q = core_rdata;
    end
  endtask
  task conclude;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    {failures, check_count, cycles, pulses} = 0;
    {I_ARST_N, core_cs, core_we, core_addr, core_wdata, core_pc} = 0;
    rows[0] = {`IUM_ADDR_CTRL_H2C, 8'hF1, 8'h01};
    rows[1] = {`IUM_ADDR_CTRL_H2C, 8'h0D, 8'h0D};
    rows[2] = {32'h83F00040, 8'hFF, 8'h00};
    rows[3] = {`IUM_ADDR_CTRL_H2C, 8'h00, 8'h00};
    repeat (3) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    $display("reset test done");
    for (i = 0; i < 4; i = i + 1) begin
      h(rows[i][47:16], rows[i][15:8], 1'b1);
      h(rows[i][47:16], 8'h00, 1'b0);
      chk("table", {8'h00, rows[i][7:0]}, {8'h00, q});
    end
    h(`IUM_ADDR_STEP_EN, 8'h01, 1'b1);
    chk("step", 16'h0001, {15'h0000, step_en});
    pulses = 0;
    repeat (4) h(`IUM_ADDR_MAN_CLK, 8'h01, 1'b1);
    chk("pulses", 16'h0004, pulses[15:0]);
    $display("register test done");
    h(`IUM_ADDR_CTRL_H2C, 8'h01, 1'b1);
    ium_host_model_inst.core_reset;
    chk("boot", 16'h0001, {15'h0000, boot});
    ium_host_model_inst.send_word(16'h1234, q);
    h(`IUM_ADDR_CTRL_H2C, 8'h00, 1'b0);
    chk("fresh", 16'h0003, {8'h00, q});
    c(`IUM_CADDR_BOOT, 8'h00, 1'b0);
    chk("cboot", 16'h0001, {8'h00, q});
    c(`IUM_CADDR_NEW_COMMAND_FLAG, 8'h00, 1'b0);
    chk("cnew", 16'h0001, {8'h00, q});
    c(`IUM_CADDR_DAT_HIGH, 8'h00, 1'b0);
    chk("high", 16'h0012, {8'h00, q});
    c(`IUM_CADDR_DAT_LOW, 8'h00, 1'b0);
    chk("low", 16'h0034, {8'h00, q});
    c(`IUM_CADDR_RDTRK, 8'h00, 1'b0);
    chk("crd", 16'h0001, {8'h00, q});
    c(`IUM_CADDR_NEW_COMMAND_FLAG, 8'h00, 1'b0);
    chk("cclr", 16'h0000, {8'h00, q});
    h(`IUM_ADDR_CTRL_H2C, 8'h00, 1'b0);
    chk("seen", 16'h0081, {8'h00, q});
    h(`IUM_ADDR_CTRL_H2C, 8'h00, 1'b1);
    ium_host_model_inst.core_reset;
    chk("run", 16'h1234, instr);
    ium_host_model_inst.send_word(16'h5678, q);
    c(`IUM_CADDR_DAT_LOW, 8'h00, 1'b0);
    repeat (2) @(posedge I_CLK);
    #1;
    chk("locked", 16'h1234, instr);
    c(12'hFF0, 8'hA5, 1'b1);
    h(`IUM_ADDR_CTRL_C2H, 8'h00, 1'b0);
    chk("back", 16'h0085, {8'h00, q});
    $display("upload test done");
    @(posedge I_CLK);
    I_ARST_N <= 1'b0;
    #1;
    chk("rst", 16'h0000, {13'h0000, step_en, boot, man_clk});
    chk("rstins", `IUM_NOP_WORD, instr);
    repeat (3) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    h(`IUM_ADDR_CTRL_H2C, 8'h00, 1'b0);
    chk("rstreg", {8'h00, `IUM_CTRL_RESET}, {8'h00, q});
    $display("mid-run reset test done");
    conclude;
  end
endmodule // tb_top
bind ium_mailbox ium_mailbox_asserts ium_mailbox_asserts_inst (
  .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_HOST_ADDR(I_HOST_ADDR),
  .I_HOST_CS(I_HOST_CS), .I_CORE_RST_N(I_CORE_RST_N),
  .O_HOST_RDATA(O_HOST_RDATA), .O_BOOT_MODE(O_BOOT_MODE),
  .O_STEP_EN(O_STEP_EN), .O_MAN_CLK(O_MAN_CLK));
